// [tplm_pkg.sv]
// Package for the twisted-pair link monitor: register map, field layout,
// timing constants and the carrier structs shared by the design.
// Assumes a 200 MHz system clock; long timers are scaled by module parameters.
package tplm_pkg;

  // Clock
  localparam int CLK_PERIOD_NS = 5;
  localparam int CYCLES_PER_MS = 1000000 / CLK_PERIOD_NS;

  // Link pulse width window, least rounds up, longest rounds down
  localparam int LP_MIN_WIDTH_NS = 60;
  localparam int LP_MAX_WIDTH_NS = 200;
  localparam int LP_MIN_CYCLES = (LP_MIN_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LP_MAX_CYCLES = LP_MAX_WIDTH_NS / CLK_PERIOD_NS;
  // Consecutive same-polarity pulses that end Link Fail
  localparam int LP_PASS_COUNT = 6;

  // Collision hold-over: two bit times at 10 Mb/s
  localparam int COL_HOLD_NS = 200;
  localparam int COL_HOLD_CYCLES = COL_HOLD_NS / CLK_PERIOD_NS;

  // Transmitted link pulse: width and period
  localparam int LP_OUT_WIDTH_NS = 100;
  localparam int LP_OUT_CYCLES = LP_OUT_WIDTH_NS / CLK_PERIOD_NS;
  localparam int LP_PERIOD_MS = 16;
  // Link loss, jabber and unjab intervals
  localparam int LINK_LOSS_MS = 100;
  localparam int JABBER_MS = 20;
  localparam int UNJAB_MS = 250;

  // Register byte offsets
  localparam logic [3:0] CTRL_OFFSET = 4'h0;
  localparam logic [3:0] STAT_OFFSET = 4'h4;
  // Control fields
  localparam int CTRL_LTD_BIT = 0;
  localparam int CTRL_LRT_BIT = 1;
  localparam int CTRL_PSEL_LSB = 2;
  localparam int CTRL_SNOOZE_BIT = 4;
  localparam logic [4:0] CTRL_RESET = 5'h00;
  // Port select encodings
  localparam logic [1:0] PSEL_PIN = 2'h0;
  localparam logic [1:0] PSEL_AUI = 2'h1;
  localparam logic [1:0] PSEL_TP = 2'h2;
  // Status fields
  localparam int STAT_LINK_BIT = 0;
  localparam int STAT_POL_BIT = 1;
  localparam int STAT_XMT_BIT = 2;
  localparam int STAT_RCV_BIT = 3;
  localparam int STAT_COL_BIT = 4;
  localparam int STAT_JAB_BIT = 5;
  localparam int STAT_LOCK_BIT = 6;

  typedef enum logic {LS_FAIL, LS_PASS} tplm_link_e;

  // Software control bits
  typedef struct packed {
    logic       snoozeMode;
    logic [1:0] portSelectField;
    logic       lowReceiveThreshold;
    logic       linkTestDisable;
  } tplm_ctrl_s;

  // Status bits shown to software and LED logic
  typedef struct packed {
    logic linkGoodStatus;
    logic linkLedOutput;
    logic polarityReversed;
    logic transmitActive;
    logic receiveActive;
    logic collision;
    logic jabberFlag;
  } tplm_status_s;

endpackage

// [tplm_link_monitor.sv]
// Twisted-pair link monitor: link test, polarity detection and correction,
// activity and collision status, jabber control, power down; Avalon-MM slave.
// Assumes analog comparators deliver receive levels asynchronously; the codec
// drives transmit and end-delimiter strobes on clk_sys.
//
// Overview of operation
// - With link test enabled, no pulses and no data lead to Link Fail.
// - Link Fail disables transmit, receive, loopback, collision until data or pulses.
// - Link status and its LED are off in Link Fail, on once link passes.
// - Link test disabled keeps functions enabled; link pulses are always sent when idle.
// - Polarity detection restarts after every reset and every Link Fail entry.
// - Link Fail accepts either polarity; exits after six same-polarity pulses.
// - Entering Link Pass takes polarity from recent pulses, then only that polarity counts.
// - A pulse counts only if its excursion lasts 60 ns to 200 ns.
// - Correction stays armed until two valid-delimiter packets agree in polarity.
// - The first valid delimiter after reset or Link Fail sets receive polarity.
// - A disagreeing delimiter sets the newest polarity; invalid delimiters change nothing.
// - After two agreeing delimiters polarity is locked until Link Fail or reset.
// - A polarity-reversed signal follows inversion and is readable and shown.
// - Power up in Link Fail; switching to twisted-pair port forces Link Fail.
// - Link Fail holds transmit, receive and collision status inactive.
// - Receive plus transmit activity is collision, held two bit times; data from receive.
// - Heartbeat test is disabled while twisted pair is selected and in Link Fail.
// - Transmit over the jabber limit disables transmitter, sets flag, asserts collision.
// - After transmit stops, unjab interval passes, then collision drops, transmitter returns.
// - Reset, coma or deselection reset logic, drive outputs low, clear status.
// - Sleep release enters Link Fail; pass needs pulses or one message.
// - Snooze keeps the receive circuitry enabled while sleep is asserted.
//
// Our own choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/100ps
module tplm_link_monitor
  import tplm_pkg::*;
#(
  parameter int LP_PERIOD_CYCLES = LP_PERIOD_MS * CYCLES_PER_MS,
  parameter int LINK_LOSS_CYCLES = LINK_LOSS_MS * CYCLES_PER_MS,
  parameter int JABBER_CYCLES    = JABBER_MS * CYCLES_PER_MS,
  parameter int UNJAB_CYCLES     = UNJAB_MS * CYCLES_PER_MS
)(
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Receive pair comparators and data (asynchronous)
  input  wire logic        rxPosLevel,
  input  wire logic        rxNegLevel,
  input  wire logic        rxCarrier,
  input  wire logic        rxData,
  input  wire logic        mediaSelectPin,
  input  wire logic        sleep_n,
  // Codec side (clk_sys)
  input  wire logic        txRequest,
  input  wire logic        txData,
  input  wire logic        endDelimiterValid,
  input  wire logic        endDelimiterNegative,
  // Outputs
  output logic             tpTxData,
  output logic             tpLinkPulse,
  output logic             rxDataOut,
  output logic             receiveCircuitEnable,
  output logic             lowReceiveThreshold,
  output logic             heartbeatEnable,
  output tplm_status_s     status
);

  // All module state except the reset synchroniser rstSync in one record
  typedef struct packed {
    logic [1:0]  posSync;
    logic [1:0]  negSync;
    logic [1:0]  carrSync;
    logic [1:0]  dataSync;
    logic [1:0]  mediaSync;
    logic [1:0]  sleepSync;
    tplm_ctrl_s  ctrl;
    logic        ack;
    logic [31:0] readData;
    tplm_link_e  linkState;
    logic        polReversed;
    logic [2:0]  lpRun;
    logic        lpRunNeg;
    logic [1:0]  etdSeen;
    logic [6:0]  posWidth;
    logic [6:0]  negWidth;
    logic [31:0] lossTimer;
    logic [31:0] lpTimer;
    logic [31:0] jabTimer;
    logic [5:0]  lpOut;
    logic        jabbed;
    logic        jabberFlag;
    logic        colActive;
    logic [5:0]  colHold;
    logic        txOut;
    logic        rxOut;
  } tplm_state_s;

  tplm_state_s st_reg;
  tplm_state_s st_next;
  logic [1:0]  rstSync;
  logic        rstInt_n;

  logic tpSelected;
  logic sleepAsserted;
  logic powerDown;
  logic enabled;
  logic posQual;
  logic negQual;
  logic pulseGood;
  logic rawCollision;
  logic txActive;
  logic rxActive;
  logic busReq;
  logic [31:0] statusWord;

  // Reset release through two flip-flops; assertion stays asynchronous
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      rstSync <= 2'h0;
    else
      rstSync <= {rstSync[0], 1'b1};
  end
  assign rstInt_n = rstSync[1];

  // Port selection, sleep and the power-down condition
  always_comb
  begin
    unique case (st_reg.ctrl.portSelectField)
      PSEL_PIN: tpSelected = st_reg.mediaSync[1];
      PSEL_TP:  tpSelected = 1'b1;
      default:  tpSelected = 1'b0;
    endcase
  end
  assign sleepAsserted = ~st_reg.sleepSync[1];
  // Sleep, coma and AUI selection all hold the logic in its reset state
  assign powerDown = ~tpSelected | sleepAsserted;
  assign receiveCircuitEnable = tpSelected & (~sleepAsserted | st_reg.ctrl.snoozeMode);
  assign lowReceiveThreshold = st_reg.ctrl.lowReceiveThreshold;

  // Outside power down, functions run in Link Pass, or in either link state when link test is off
  assign enabled = ~powerDown & ((st_reg.linkState == LS_PASS) | st_reg.ctrl.linkTestDisable);

  // Pulse qualification at the trailing edge of each excursion
  assign posQual = ~st_reg.posSync[1] && st_reg.posWidth >= 7'(LP_MIN_CYCLES)
                   && st_reg.posWidth <= 7'(LP_MAX_CYCLES);
  assign negQual = ~st_reg.negSync[1] && st_reg.negWidth >= 7'(LP_MIN_CYCLES)
                   && st_reg.negWidth <= 7'(LP_MAX_CYCLES);
  // In Link Pass only the chosen polarity is recognised
  assign pulseGood = st_reg.polReversed ? negQual : posQual;

  // Activity status, gated off in power down and in Link Fail with link test on
  assign txActive = txRequest & enabled & ~st_reg.jabbed;
  assign rxActive = st_reg.carrSync[1] & enabled;
  assign rawCollision = txRequest & rxActive;

  // Status outputs
  assign status.linkGoodStatus   = st_reg.linkState == LS_PASS;
  assign status.linkLedOutput    = st_reg.linkState == LS_PASS;
  assign status.polarityReversed = st_reg.polReversed;
  assign status.transmitActive   = txActive;
  assign status.receiveActive    = rxActive;
  assign status.collision        = (st_reg.colActive | st_reg.jabbed) & enabled;
  assign status.jabberFlag       = st_reg.jabberFlag;
  assign heartbeatEnable = ~(tpSelected & (st_reg.linkState == LS_FAIL));
  assign tpTxData    = st_reg.txOut;
  assign tpLinkPulse = st_reg.lpOut != 6'h00;
  assign rxDataOut   = st_reg.rxOut;

  // Avalon: one wait cycle, then the answer with waitrequest low
  assign busReq = avs_read | avs_write;
  assign avs_waitrequest = busReq & ~st_reg.ack;
  assign avs_readdata = st_reg.readData;
  always_comb
  begin
    statusWord = 32'h0;
    statusWord[STAT_LINK_BIT] = status.linkGoodStatus;
    statusWord[STAT_POL_BIT]  = status.polarityReversed;
    statusWord[STAT_XMT_BIT]  = status.transmitActive;
    statusWord[STAT_RCV_BIT]  = status.receiveActive;
    statusWord[STAT_COL_BIT]  = status.collision;
    statusWord[STAT_JAB_BIT]  = status.jabberFlag;
    statusWord[STAT_LOCK_BIT] = st_reg.etdSeen == 2'h2;
  end

  // Next-state logic
  always_comb
  begin
    st_next = st_reg;
    // Two-stage synchronisers
    st_next.posSync   = {st_reg.posSync[0], rxPosLevel};
    st_next.negSync   = {st_reg.negSync[0], rxNegLevel};
    st_next.carrSync  = {st_reg.carrSync[0], rxCarrier};
    st_next.dataSync  = {st_reg.dataSync[0], rxData};
    st_next.mediaSync = {st_reg.mediaSync[0], mediaSelectPin};
    st_next.sleepSync = {st_reg.sleepSync[0], sleep_n};

    // Bus access; the status jabber bit clears on write of one
    st_next.ack = busReq & ~st_reg.ack;
    if (busReq && !st_reg.ack)
    begin
      st_next.readData = 32'h0;
      if (avs_read && avs_address == CTRL_OFFSET)
        st_next.readData = {27'h0, st_reg.ctrl};
      else if (avs_read && avs_address == STAT_OFFSET)
        st_next.readData = statusWord;
      if (avs_write && avs_address == CTRL_OFFSET)
      begin
        st_next.ctrl.linkTestDisable     = avs_writedata[CTRL_LTD_BIT];
        st_next.ctrl.lowReceiveThreshold = avs_writedata[CTRL_LRT_BIT];
        st_next.ctrl.portSelectField     = avs_writedata[CTRL_PSEL_LSB +: 2];
        st_next.ctrl.snoozeMode          = avs_writedata[CTRL_SNOOZE_BIT];
      end
      if (avs_write && avs_address == STAT_OFFSET && avs_writedata[STAT_JAB_BIT])
        st_next.jabberFlag = 1'b0;
    end

    // Excursion width counters, saturating, cleared after each trailing edge
    st_next.posWidth = st_reg.posSync[1] ? ((st_reg.posWidth == 7'h7f) ? st_reg.posWidth
                       : st_reg.posWidth + 7'h01) : 7'h00;
    st_next.negWidth = st_reg.negSync[1] ? ((st_reg.negWidth == 7'h7f) ? st_reg.negWidth
                       : st_reg.negWidth + 7'h01) : 7'h00;

    // Link state machine
    unique case (st_reg.linkState)
      LS_FAIL:
      begin
        st_next.lossTimer = 32'h0;
        if (posQual || negQual)
        begin
          // Either polarity counts here; a change of polarity restarts the run
          if (st_reg.lpRun != 3'h0 && st_reg.lpRunNeg == negQual)
            st_next.lpRun = st_reg.lpRun + 3'h1;
          else
            st_next.lpRun = 3'h1;
          st_next.lpRunNeg = negQual;
          if (st_next.lpRun == 3'(LP_PASS_COUNT))
          begin
            st_next.linkState = LS_PASS;
            st_next.polReversed = negQual;
          end
        end
        if (endDelimiterValid)
        begin
          // One received message also brings the link up and sets polarity
          st_next.linkState = LS_PASS;
          st_next.polReversed = endDelimiterNegative;
          st_next.etdSeen = 2'h1;
        end
      end
      LS_PASS:
      begin
        if (pulseGood || st_reg.carrSync[1])
          st_next.lossTimer = 32'h0;
        else
          st_next.lossTimer = st_reg.lossTimer + 32'h1;
        // Armed correction follows each valid delimiter until two agree
        if (endDelimiterValid && st_reg.etdSeen != 2'h2)
        begin
          st_next.polReversed = endDelimiterNegative;
          if (st_reg.etdSeen == 2'h1 && endDelimiterNegative == st_reg.polReversed)
            st_next.etdSeen = 2'h2;
          else
            st_next.etdSeen = 2'h1;
        end
        if (st_reg.lossTimer >= 32'(LINK_LOSS_CYCLES) && !st_reg.ctrl.linkTestDisable)
        begin
          // Fresh Link Fail re-arms polarity detection
          st_next.linkState = LS_FAIL;
          st_next.lpRun = 3'h0;
          st_next.etdSeen = 2'h0;
        end
      end
    endcase

    // Collision while both pairs active, then held two bit times
    if (rawCollision)
    begin
      st_next.colActive = 1'b1;
      st_next.colHold = 6'(COL_HOLD_CYCLES);
    end
    else if (st_reg.colHold != 6'h00)
      st_next.colHold = st_reg.colHold - 6'h01;
    else
      st_next.colActive = 1'b0;

    // Jabber: long transmit trips it, idle for the unjab time releases it
    if (!st_reg.jabbed)
    begin
      st_next.jabTimer = (txRequest && enabled) ? st_reg.jabTimer + 32'h1 : 32'h0;
      if (st_reg.jabTimer >= 32'(JABBER_CYCLES - 1))
      begin
        st_next.jabbed = 1'b1;
        st_next.jabTimer = 32'h0;
      end
    end
    else
    begin
      st_next.jabTimer = txRequest ? 32'h0 : st_reg.jabTimer + 32'h1;
      // A transmit stream in the deciding cycle restarts the unjab wait
      if (!txRequest && st_reg.jabTimer >= 32'(UNJAB_CYCLES - 1))
      begin
        st_next.jabbed = 1'b0;
        st_next.jabTimer = 32'h0;
      end
    end
    // Hardware set wins over a software clear in the same cycle
    if (st_next.jabbed && !st_reg.jabbed)
      st_next.jabberFlag = 1'b1;

    // Link pulses while transmit idles, whatever the link test setting
    if (st_reg.lpOut != 6'h00)
      st_next.lpOut = st_reg.lpOut - 6'h01;
    if (txRequest)
      st_next.lpTimer = 32'h0;
    else if (st_reg.lpTimer >= 32'(LP_PERIOD_CYCLES - 1))
    begin
      st_next.lpTimer = 32'h0;
      st_next.lpOut = 6'(LP_OUT_CYCLES);
    end
    else
      st_next.lpTimer = st_reg.lpTimer + 32'h1;

    // Driver and corrected receive data; during collision data still comes from the pair
    // Gated by the next jabber state so the driver stops in the cycle jabber trips
    st_next.txOut = txData & txRequest & enabled & ~st_next.jabbed;
    st_next.rxOut = (st_reg.dataSync[1] ^ st_reg.polReversed) & rxActive;

    // Power down resets all link logic and quiets the drivers
    if (powerDown)
    begin
      st_next.linkState = LS_FAIL;
      st_next.polReversed = 1'b0;
      st_next.lpRun = 3'h0;
      st_next.etdSeen = 2'h0;
      st_next.lossTimer = 32'h0;
      st_next.lpTimer = 32'h0;
      st_next.jabTimer = 32'h0;
      st_next.lpOut = 6'h00;
      st_next.jabbed = 1'b0;
      st_next.jabberFlag = 1'b0;
      st_next.colActive = 1'b0;
      st_next.colHold = 6'h00;
      st_next.txOut = 1'b0;
      st_next.rxOut = 1'b0;
    end
  end

  // State register; reset value puts the unit in Link Fail
  always_ff @(posedge clk_sys or negedge rstInt_n)
  begin
    if (!rstInt_n)
    begin
      st_reg <= '0;
      st_reg.ctrl <= CTRL_RESET;
      st_reg.linkState <= LS_FAIL;
    end
    else
      st_reg <= st_next;
  end

  // Checks
  property p_fail_no_link;
    @(posedge clk_sys) disable iff (!rstInt_n)
    st_reg.linkState == LS_FAIL |-> !status.linkGoodStatus && !status.linkLedOutput;
  endproperty
  a_fail_no_link: assert property (p_fail_no_link) else $error("Link status on in Link Fail");

  property p_fail_quiet;
    @(posedge clk_sys) disable iff (!rstInt_n)
    st_reg.linkState == LS_FAIL && !st_reg.ctrl.linkTestDisable
    |-> !status.transmitActive && !status.receiveActive && !status.collision;
  endproperty
  a_fail_quiet: assert property (p_fail_quiet) else $error("Activity shown in Link Fail");

  property p_powerdown;
    @(posedge clk_sys) disable iff (!rstInt_n)
    powerDown |=> !tpTxData && !tpLinkPulse && !status.linkGoodStatus && !status.collision;
  endproperty
  a_powerdown: assert property (p_powerdown) else $error("Outputs active after power down");

  property p_first_etd;
    @(posedge clk_sys) disable iff (!rstInt_n)
    !powerDown && endDelimiterValid && st_reg.etdSeen == 2'h0
    |=> st_reg.polReversed == $past(endDelimiterNegative) && st_reg.etdSeen == 2'h1;
  endproperty
  a_first_etd: assert property (p_first_etd) else $error("First delimiter did not set polarity");

  property p_locked;
    @(posedge clk_sys) disable iff (!rstInt_n)
    st_reg.etdSeen == 2'h2 && !powerDown && st_reg.linkState == LS_PASS
    && st_reg.lossTimer < 32'(LINK_LOSS_CYCLES) |=> $stable(st_reg.polReversed);
  endproperty
  a_locked: assert property (p_locked) else $error("Locked polarity changed");

  property p_jab_set;
    @(posedge clk_sys) disable iff (!rstInt_n)
    $rose(st_reg.jabbed) |-> st_reg.jabberFlag && !status.transmitActive && !tpTxData ##0
    (status.collision || !enabled);
  endproperty
  a_jab_set: assert property (p_jab_set) else $error("Jabber entry incomplete");

  property p_unjab;
    @(posedge clk_sys) disable iff (!rstInt_n)
    $fell(st_reg.jabbed) && !$past(powerDown) |-> !$past(txRequest) && !$past(txRequest, 2);
  endproperty
  a_unjab: assert property (p_unjab) else $error("Unjab while transmit present");

  property p_col_hold;
    @(posedge clk_sys) disable iff (!rstInt_n)
    $fell(rawCollision) && !powerDown ##1 !powerDown |-> st_reg.colActive;
  endproperty
  a_col_hold: assert property (p_col_hold) else $error("Collision not held after activity");

  property p_pass_entry;
    @(posedge clk_sys) disable iff (!rstInt_n)
    $rose(st_reg.linkState == LS_PASS) |-> $past(st_reg.lpRun) == 3'(LP_PASS_COUNT - 1)
    || $past(endDelimiterValid);
  endproperty
  a_pass_entry: assert property (p_pass_entry) else $error("Link Pass without pulses or data");

  c_pass: cover property (@(posedge clk_sys) disable iff (!rstInt_n)
    $rose(st_reg.linkState == LS_PASS));
  c_lock: cover property (@(posedge clk_sys) disable iff (!rstInt_n)
    $rose(st_reg.etdSeen == 2'h2));
  c_jabber: cover property (@(posedge clk_sys) disable iff (!rstInt_n) $fell(st_reg.jabbed));
  c_collision: cover property (@(posedge clk_sys) disable iff (!rstInt_n) $rose(status.collision));

endmodule

// [tplm_partner.sv]
// Far-end link partner: link pulses and carrier on the receive pair.
// Assumes the bench calls its tasks from code aligned to clk_sys.
`timescale 1ns/100ps
module tplm_partner (
  input  wire logic clk_sys,
  output logic      rxPosLevel,
  output logic      rxNegLevel,
  output logic      rxCarrier,
  output logic      rxData
);
  // Quiet line at time zero
  initial
  begin
    rxPosLevel = 1'b0;
    rxNegLevel = 1'b0;
    rxCarrier = 1'b0;
    rxData = 1'b0;
  end
  // Data changes every cycle, so a stale value never passes for a match
  always @(posedge clk_sys) rxData <= ~rxData;
  // One excursion of chosen polarity and width, then a quiet gap
  task automatic pulse(input logic neg, input int w);
    @(posedge clk_sys);
    if (neg)
      rxNegLevel <= 1'b1;
    else
      rxPosLevel <= 1'b1;
    repeat (w) @(posedge clk_sys);
    rxPosLevel <= 1'b0;
    rxNegLevel <= 1'b0;
    repeat (20) @(posedge clk_sys);
  endtask
  // Receive activity level
  task automatic carrier(input logic on);
    @(posedge clk_sys);
    rxCarrier <= on;
  endtask
endmodule

// [tb_top.sv]
// Bench for the link monitor: Avalon-MM register access, partner pulses.
// Assumes shortened timers: period 200, loss 1000, jabber 300, unjab 500.
`timescale 1ns/100ps
module tb_top;
  import tplm_pkg::*;
  logic         clk_sys, reset_n, avs_read, avs_write, avs_waitrequest;
  logic         rxPosLevel, rxNegLevel, rxCarrier, rxData, sleep_n, txRequest, txData;
  logic         endDelimiterValid, endDelimiterNegative, tpTxData, tpLinkPulse;
  logic         rxDataOut, receiveCircuitEnable, lowReceiveThreshold, heartbeatEnable;
  logic         mediaSelectPin;
  logic [3:0]   avs_address;
  logic [31:0]  avs_writedata, avs_readdata, rd;
  tplm_status_s status;
  int           miscompares, n_tests, i;

  tplm_link_monitor #(.LP_PERIOD_CYCLES(200), .LINK_LOSS_CYCLES(1000),
    .JABBER_CYCLES(300), .UNJAB_CYCLES(500)) dut (.clk_sys, .reset_n,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .rxPosLevel, .rxNegLevel, .rxCarrier, .rxData, .mediaSelectPin, .sleep_n,
    .txRequest, .txData, .endDelimiterValid, .endDelimiterNegative, .tpTxData,
    .tpLinkPulse, .rxDataOut, .receiveCircuitEnable, .lowReceiveThreshold,
    .heartbeatEnable, .status);
  tplm_partner p (.clk_sys, .rxPosLevel, .rxNegLevel, .rxCarrier, .rxData);

  // 200 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // Transmit data keeps moving
  always @(posedge clk_sys) txData <= ~txData;

  task results();
    if (miscompares == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // One Avalon access; held until waitrequest is sampled low, bounded
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    for (i = 0; i < 20; i++)
    begin
      @(posedge clk_sys);
      if (avs_waitrequest === 1'b0)
        break;
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (i == 20)
    begin
      miscompares++;
      results();
    end
  endtask
  // One-cycle delimiter strobe from the codec
  task delim(input logic v, input logic neg);
    @(posedge clk_sys);
    endDelimiterValid <= v;
    endDelimiterNegative <= neg;
    @(posedge clk_sys);
    endDelimiterValid <= 1'b0;
    cyc(3);
  endtask

  // Main sequence
  initial
  begin
    {miscompares, n_tests} = '0;
    {reset_n, avs_read, avs_write, txRequest, txData, endDelimiterValid} = '0;
    {endDelimiterNegative, avs_address, avs_writedata} = '0;
    sleep_n = 1'b1;
    mediaSelectPin = 1'b0;
    cyc(16);
    reset_n <= 1'b1;
    cyc(4);
    chk("status", 32'h0, 32'(status));
    chk("rxen", 32'h0, 32'(receiveCircuitEnable));
    // Pin selection picks the twisted pair while the field is left at zero
    mediaSelectPin <= 1'b1;
    cyc(4);
    chk("rxen", 32'h1, 32'(receiveCircuitEnable));
    bus(1'b0, CTRL_OFFSET, 32'h0);
    chk("ctrl", 32'(CTRL_RESET), rd);
    bus(1'b1, 4'h8, 32'hffff_ffff);
    bus(1'b0, 4'h8, 32'h0);
    chk("unmapped", 32'h0, rd);
    bus(1'b1, CTRL_OFFSET, 32'h0000_000a);
    bus(1'b0, CTRL_OFFSET, 32'h0);
    chk("ctrl", 32'h0000_000a, rd);
    chk("lrt", 32'h1, 32'(lowReceiveThreshold));
    chk("sqe", 32'h0, 32'(heartbeatEnable));
    // Short pulses, then five of each polarity: still failed
    for (int k = 0; k < 6; k++) p.pulse(1'b0, 8);
    for (int k = 0; k < 10; k++) p.pulse(k < 5, 14);
    chk("link", 32'h0, 32'(status.linkGoodStatus));
    txRequest <= 1'b1;
    cyc(5);
    chk("xmt", 32'h0, 32'(status.transmitActive));
    txRequest <= 1'b0;
    p.pulse(1'b0, 14);
    chk("link", 32'h1, 32'(status.linkGoodStatus));
    chk("led", 32'h1, 32'(status.linkLedOutput));
    chk("pol", 32'h0, 32'(status.polarityReversed));
    // Delimiter sequence: set, ignore invalid, flip, lock, ignore
    delim(1'b1, 1'b1);
    chk("pol", 32'h1, 32'(status.polarityReversed));
    delim(1'b0, 1'b0);
    chk("pol", 32'h1, 32'(status.polarityReversed));
    delim(1'b1, 1'b0);
    chk("pol", 32'h0, 32'(status.polarityReversed));
    delim(1'b1, 1'b0);
    delim(1'b1, 1'b1);
    bus(1'b0, STAT_OFFSET, 32'h0);
    chk("stat", 32'h0000_0041, rd);
    // Collision and its hold-over
    txRequest <= 1'b1;
    p.carrier(1'b1);
    cyc(5);
    chk("col", 32'h1, 32'(status.collision));
    chk("rcv", 32'h1, 32'(status.receiveActive));
    chk("rxd", {31'h0, ~rxData}, {31'h0, rxDataOut});
    p.carrier(1'b0);
    cyc(30);
    chk("col", 32'h1, 32'(status.collision));
    cyc(20);
    chk("col", 32'h0, 32'(status.collision));
    txRequest <= 1'b0;
    for (i = 0; i < 300 && tpLinkPulse !== 1'b1; i++) cyc(1);
    chk("lpout", 32'h1, 32'(tpLinkPulse));
    if (i == 300)
      results();
    cyc(1100);
    chk("link", 32'h0, 32'(status.linkGoodStatus));
    // Link test off, then jabber and unjab
    bus(1'b1, CTRL_OFFSET, 32'h0000_0009);
    txRequest <= 1'b1;
    cyc(5);
    chk("xmt", 32'h1, 32'(status.transmitActive));
    chk("txd", {31'h0, ~txData}, {31'h0, tpTxData});
    cyc(310);
    chk("jab", 32'h1, 32'(status.jabberFlag));
    chk("jcol", 32'h1, 32'(status.collision));
    txRequest <= 1'b0;
    cyc(440);
    chk("jcol", 32'h1, 32'(status.collision));
    cyc(80);
    chk("jcol", 32'h0, 32'(status.collision));
    // Sleep, with and without snooze
    sleep_n <= 1'b0;
    cyc(4);
    chk("rxen", 32'h0, 32'(receiveCircuitEnable));
    chk("status", 32'h0, 32'(status));
    bus(1'b1, CTRL_OFFSET, 32'h0000_0019);
    cyc(2);
    chk("rxen", 32'h1, 32'(receiveCircuitEnable));
    results();
  end
endmodule
